/* File: pkg/flow_csr_cfg.svh */
// Constants for the port 0 flow control and fabric data register bank
// Summary of operation
// - Bit 6 read/write enables half-duplex backpressure on port 0.
// - Read-only bit 5 shows actual duplex: 0 full, 1 half.
// - Read-only bit 4 shows receive flow control currently in effect.
// - Read-only bit 3 shows transmit flow control currently in effect.
// - Bit 2 enables pause detection when manual or negotiation off.
// - Bit 1 enables pause generation when manual or negotiation off.
// - Manual-select clear, negotiation on: negotiated result decides.
// - Manual-select set: manual enables decide in full duplex.
// - External MAC modes hold manual-select at 1, read-only.
// - External MAC: manual-select resets to 1, loader cannot overwrite.
// - Register contents never alter the advertised flow capabilities.
// - Backpressure and manual enables reset from strap inputs.
// - Current duplex and flow status reset from combined straps.
// - Indirect data register resets to zero, holds fabric word.
// - Direction read: host read returns data fetched from fabric.
// - Direction write: host read returns value last written by host.
// - Command bit 31 starts access, self-clears when access completes.
// - Command bit 30 selects direction: 0 write, 1 read.
// - With bit 29 set, data write starts access, index then increments if direction is write.
`ifndef FLOW_CSR_CFG_SVH
`define FLOW_CSR_CFG_SVH
`define FC_FLOW_CFG_ADDR   12'h1A8
`define FC_IND_DATA_ADDR   12'h1AC
`define FC_IND_CMD_ADDR    12'h1B0
`define FC_ADDR_W          12
`define FC_BIT_BP          6
`define FC_BIT_DUP         5
`define FC_BIT_CUR_RX      4
`define FC_BIT_CUR_TX      3
`define FC_BIT_RX_EN       2
`define FC_BIT_TX_EN       1
`define FC_BIT_MANUAL      0
`define FC_BIT_BUSY        31
`define FC_BIT_DIR         30
`define FC_BIT_AUTOINC     29
`define FC_IDX_W           16
`define FC_DATA_RESET      32'h0000_0000
`define FC_RESP_OKAY       2'h0
`define FC_RESP_SLVERR     2'h2
`endif

/* File: pkg/flow_csr_pkg.sv */
// Types for the port 0 flow control and fabric data register bank
package flow_csr_pkg;
  typedef enum logic [1:0] {ACC_IDLE, ACC_REQ, ACC_WAIT} acc_state_type;
endpackage : flow_csr_pkg

/* File: hdl/flow_resolve.sv */
// Resolution of effective port 0 flow control from manual and negotiated
module flow_resolve (
  input  wire logic i_manual,
  input  wire logic i_aneg_en,
  input  wire logic i_half_duplex,
  input  wire logic i_man_rx,
  input  wire logic i_man_tx,
  input  wire logic i_neg_rx,
  input  wire logic i_neg_tx,
  output logic      o_eff_rx,
  output logic      o_eff_tx
);
  logic use_manual;

  assign use_manual = i_manual | ~i_aneg_en;
  assign o_eff_rx = ~i_half_duplex & (use_manual ? i_man_rx : i_neg_rx);
  assign o_eff_tx = ~i_half_duplex & (use_manual ? i_man_tx : i_neg_tx);
endmodule : flow_resolve

/* File: hdl/port0_flow_ctrl_and_indirect_data_word.sv */
// Port 0 flow control register and fabric indirect data register bank
`include "flow_csr_cfg.svh"
module port0_flow_ctrl_and_indirect_data_word (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // AXI4-Lite slave
  input  wire logic [11:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [11:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Straps and mode
  input  wire logic        I_EXT_MAC_MODE,
  input  wire logic        I_STRAP_BP_EN,
  input  wire logic        I_STRAP_FD_FC,
  input  wire logic        I_STRAP_MANUAL_FC,
  input  wire logic        I_STRAP_HALF_DUPLEX,
  // Port 0 link status
  input  wire logic        I_ANEG_ENABLE,
  input  wire logic        I_LINK_HALF_DUPLEX,
  input  wire logic        I_NEG_RX_PAUSE,
  input  wire logic        I_NEG_TX_PAUSE,
  // Port 0 flow control outputs to MAC
  output logic             O_BACKPRESSURE_EN,
  output logic             O_RX_PAUSE_EN,
  output logic             O_TX_PAUSE_EN,
  // Fabric register access port
  output logic             O_FAB_REQ,
  output logic             O_FAB_READ,
  output logic [15:0]      O_FAB_INDEX,
  output logic [31:0]      O_FAB_WDATA,
  input  wire logic        I_FAB_ACK,
  input  wire logic [31:0] I_FAB_RDATA
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  logic        aw_held_r;
  logic [11:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic [31:0] wmask;
  logic        backpressure_enable_r;
  logic        manual_pause_detect_enable_r;
  logic        manual_pause_generate_enable_r;
  logic        flow_override_select_r;
  logic        current_duplex_status_r;
  logic        current_rx_flow_status_r;
  logic        current_tx_flow_status_r;
  logic        boot_r;
  logic        eff_rx;
  logic        eff_tx;
  logic [31:0] host_data_r;
  logic [31:0] fab_data_r;
  logic [31:0] cmd_r;
  logic        access_in_progress;
  logic        access_direction;
  logic [15:0] fabric_register_index;
  logic        start_cmd;
  logic        start_auto;
  flow_csr_pkg::acc_state_type state_r;
  logic [31:0] flow_rd;
  logic [31:0] rd_word;
  logic        rd_hit;

  // --------------------------------------------------------------
  // AXI4-Lite write channel capture
  // --------------------------------------------------------------
  assign O_AWREADY = ~aw_held_r & ~O_BVALID;
  assign O_WREADY  = ~w_held_r & ~O_BVALID;
  assign wr_go     = aw_held_r & w_held_r & ~O_BVALID;

  // Address hold
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end
    else if (I_AWVALID && O_AWREADY)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= I_AWADDR;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;

  // Data hold
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (I_WVALID && O_WREADY)
    begin
      w_held_r <= 1'b1;
      w_data_r <= I_WDATA;
      w_strb_r <= I_WSTRB;
    end
    else if (wr_go)
      w_held_r <= 1'b0;

  // Byte strobes expanded to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_mask
      assign wmask[8*g +: 8] = {8{w_strb_r[g]}};
    end
  endgenerate

  // Write response
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      O_BVALID <= 1'b0;
      O_BRESP  <= `FC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      O_BVALID <= 1'b1;
      if (aw_addr_r[11:2] == `FC_FLOW_CFG_ADDR >> 2 ||
          aw_addr_r[11:2] == `FC_IND_DATA_ADDR >> 2 ||
          aw_addr_r[11:2] == `FC_IND_CMD_ADDR >> 2)
        O_BRESP <= `FC_RESP_OKAY;
      else
        O_BRESP <= `FC_RESP_SLVERR;
    end
    else if (I_BREADY)
      O_BVALID <= 1'b0;

  // --------------------------------------------------------------
  // Flow configuration register
  // --------------------------------------------------------------
  // Straps are caught in the first cycle after reset release
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      boot_r <= 1'b1;
    else
      boot_r <= 1'b0;

  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      backpressure_enable_r          <= 1'b0;
      manual_pause_detect_enable_r   <= 1'b0;
      manual_pause_generate_enable_r <= 1'b0;
    end
    else if (boot_r)
    begin
      backpressure_enable_r          <= I_STRAP_BP_EN;
      manual_pause_detect_enable_r   <= I_STRAP_FD_FC;
      manual_pause_generate_enable_r <= I_STRAP_FD_FC;
    end
    else if (wr_go && aw_addr_r[11:2] == `FC_FLOW_CFG_ADDR >> 2 &&
             w_strb_r[0])
    begin
      backpressure_enable_r <= w_data_r[`FC_BIT_BP];
      manual_pause_detect_enable_r <= w_data_r[`FC_BIT_RX_EN];
      manual_pause_generate_enable_r <= w_data_r[`FC_BIT_TX_EN];
    end

  // forced manual select in external MAC modes
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      flow_override_select_r <= 1'b1;
    else if (I_EXT_MAC_MODE)
      flow_override_select_r <= 1'b1;
    else if (boot_r)
      flow_override_select_r <= I_STRAP_MANUAL_FC;
    else if (wr_go && aw_addr_r[11:2] == `FC_FLOW_CFG_ADDR >> 2 &&
             w_strb_r[0])
      flow_override_select_r <= w_data_r[`FC_BIT_MANUAL];

  // Effective flow control resolution
  flow_resolve u_resolve (
    .i_manual      (flow_override_select_r),
    .i_aneg_en     (I_ANEG_ENABLE),
    .i_half_duplex (I_LINK_HALF_DUPLEX),
    .i_man_rx      (manual_pause_detect_enable_r),
    .i_man_tx      (manual_pause_generate_enable_r),
    .i_neg_rx      (I_NEG_RX_PAUSE),
    .i_neg_tx      (I_NEG_TX_PAUSE),
    .o_eff_rx      (eff_rx),
    .o_eff_tx      (eff_tx)
  );

  // status bits from straps, then live
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      current_duplex_status_r  <= 1'b0;
      current_rx_flow_status_r <= 1'b0;
      current_tx_flow_status_r <= 1'b0;
    end
    else if (boot_r)
    begin
      current_duplex_status_r  <= I_STRAP_HALF_DUPLEX;
      current_rx_flow_status_r <= ~I_STRAP_HALF_DUPLEX & I_STRAP_FD_FC;
      current_tx_flow_status_r <= ~I_STRAP_HALF_DUPLEX & I_STRAP_FD_FC;
    end
    else
    begin
      current_duplex_status_r  <= I_LINK_HALF_DUPLEX;
      current_rx_flow_status_r <= eff_rx;
      current_tx_flow_status_r <= eff_tx;
    end

  // MAC controls only; advertisement is never driven from here
  assign O_BACKPRESSURE_EN = backpressure_enable_r;
  assign O_RX_PAUSE_EN     = current_rx_flow_status_r;
  assign O_TX_PAUSE_EN     = current_tx_flow_status_r;

  // --------------------------------------------------------------
  // Indirect command and data
  // --------------------------------------------------------------
  assign access_in_progress    = cmd_r[`FC_BIT_BUSY];
  assign access_direction      = cmd_r[`FC_BIT_DIR];
  assign fabric_register_index = cmd_r[`FC_IDX_W-1:0];
  assign start_cmd  = wr_go && aw_addr_r[11:2] == `FC_IND_CMD_ADDR >> 2 &&
                      w_strb_r[3] && w_data_r[`FC_BIT_BUSY];
  assign start_auto = wr_go && aw_addr_r[11:2] == `FC_IND_DATA_ADDR >> 2 &&
                      cmd_r[`FC_BIT_AUTOINC];

  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      host_data_r <= `FC_DATA_RESET;
    else if (wr_go && aw_addr_r[11:2] == `FC_IND_DATA_ADDR >> 2)
      host_data_r <= (host_data_r & ~wmask) | (w_data_r & wmask);

  // Fabric read data capture
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      fab_data_r <= `FC_DATA_RESET;
    else if (state_r == flow_csr_pkg::ACC_WAIT && I_FAB_ACK &&
             access_direction)
      fab_data_r <= I_FAB_RDATA;

  // busy set on start, cleared on completion
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      cmd_r <= 32'h0000_0000;
    else if (state_r == flow_csr_pkg::ACC_WAIT && I_FAB_ACK)
    begin
      cmd_r[`FC_BIT_BUSY] <= 1'b0;
      if (cmd_r[`FC_BIT_AUTOINC] && !access_direction)
        cmd_r[`FC_IDX_W-1:0] <= fabric_register_index + 16'h0001;
    end
    else if (start_auto && !access_in_progress)
      cmd_r[`FC_BIT_BUSY] <= 1'b1;
    else if (wr_go && aw_addr_r[11:2] == `FC_IND_CMD_ADDR >> 2 &&
             !access_in_progress)
      cmd_r <= (cmd_r & ~wmask) | (w_data_r & wmask);

  // Fabric access sequencer
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
      state_r <= flow_csr_pkg::ACC_IDLE;
    else
      case (state_r)
        flow_csr_pkg::ACC_IDLE:
          if ((start_cmd || start_auto) && !access_in_progress)
            state_r <= flow_csr_pkg::ACC_REQ;
        flow_csr_pkg::ACC_REQ:
          state_r <= flow_csr_pkg::ACC_WAIT;
        flow_csr_pkg::ACC_WAIT:
          if (I_FAB_ACK)
            state_r <= flow_csr_pkg::ACC_IDLE;
        default:
          state_r <= flow_csr_pkg::ACC_IDLE;
      endcase

  // Request held until acknowledged
  assign O_FAB_REQ   = state_r != flow_csr_pkg::ACC_IDLE;
  assign O_FAB_READ  = access_direction;
  assign O_FAB_INDEX = fabric_register_index;
  assign O_FAB_WDATA = host_data_r;

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  // reserved bits read zero
  assign flow_rd = {25'h0000000, backpressure_enable_r,
                    current_duplex_status_r, current_rx_flow_status_r,
                    current_tx_flow_status_r, manual_pause_detect_enable_r,
                    manual_pause_generate_enable_r, flow_override_select_r};

  // Read decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (I_ARADDR[11:2] == `FC_FLOW_CFG_ADDR >> 2)
      rd_word = flow_rd;
    else if (I_ARADDR[11:2] == `FC_IND_DATA_ADDR >> 2)
      rd_word = access_direction ? fab_data_r : host_data_r;
    else if (I_ARADDR[11:2] == `FC_IND_CMD_ADDR >> 2)
      rd_word = cmd_r;
    else
      rd_hit = 1'b0;
  end

  assign O_ARREADY = ~O_RVALID;

  // Read response register
  always_ff @(posedge I_CORE_CLK)
    if (!I_RST_N)
    begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= `FC_RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd_word;
      O_RRESP  <= rd_hit ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
    end
    else if (I_RREADY)
      O_RVALID <= 1'b0;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_ext_mac_manual: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) $past(I_EXT_MAC_MODE) && !boot_r
      |-> flow_override_select_r)
    else $error("manual select not forced in external MAC mode");

  a_half_no_pause: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) !boot_r && $past(I_LINK_HALF_DUPLEX) &&
      !$past(boot_r)
      |-> !current_rx_flow_status_r && !current_tx_flow_status_r)
    else $error("pause active in half duplex");

  a_dup_follow: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) !$past(boot_r) && !boot_r
      |-> current_duplex_status_r == $past(I_LINK_HALF_DUPLEX))
    else $error("duplex status does not follow link");

  a_rsvd_zero: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) I_ARVALID && O_ARREADY &&
      I_ARADDR[11:2] == `FC_FLOW_CFG_ADDR >> 2
      |=> O_RDATA[31:7] == 25'h0000000)
    else $error("reserved bits not zero");

  sequence s_start;
    state_r == flow_csr_pkg::ACC_IDLE && (start_cmd || start_auto) &&
      !access_in_progress;
  endsequence
  a_start_busy: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) s_start |=> access_in_progress && O_FAB_REQ)
    else $error("access start did not set busy");

  a_done_clear: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) state_r == flow_csr_pkg::ACC_WAIT && I_FAB_ACK
      |=> !access_in_progress && !O_FAB_REQ)
    else $error("busy not cleared on completion");

  a_rd_data_src: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) I_ARVALID && O_ARREADY &&
      I_ARADDR[11:2] == `FC_IND_DATA_ADDR >> 2 && access_direction
      |=> O_RDATA == $past(fab_data_r))
    else $error("read data not from fabric");

  a_auto_inc: assert property (@(posedge I_CORE_CLK)
    disable iff (!I_RST_N) state_r == flow_csr_pkg::ACC_WAIT && I_FAB_ACK &&
      cmd_r[`FC_BIT_AUTOINC] && !access_direction
      |=> fabric_register_index == $past(fabric_register_index) + 16'h0001)
    else $error("index not incremented");

endmodule : port0_flow_ctrl_and_indirect_data_word

/* File: testbench/testbench.sv */
// Self-checking bench for the port 0 flow and fabric data register bank
`include "flow_csr_cfg.svh"
`define CHECK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        I_CORE_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY;
  logic        I_ARVALID, I_RREADY, I_EXT_MAC_MODE, I_STRAP_BP_EN;
  logic        I_STRAP_FD_FC, I_STRAP_MANUAL_FC, I_STRAP_HALF_DUPLEX;
  logic        I_ANEG_ENABLE, I_LINK_HALF_DUPLEX, I_NEG_RX_PAUSE;
  logic        I_NEG_TX_PAUSE, I_FAB_ACK;
  logic [11:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, I_FAB_RDATA, O_RDATA, O_FAB_WDATA, rd, seen_wdata;
  logic [3:0]  I_WSTRB;
  logic [1:0]  O_BRESP, O_RRESP, rs;
  logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic        O_BACKPRESSURE_EN, O_RX_PAUSE_EN, O_TX_PAUSE_EN;
  logic        O_FAB_REQ, O_FAB_READ, seen_read;
  logic [15:0] O_FAB_INDEX, seen_index;
  int          fails, total_checks, req_cnt;

  port0_flow_ctrl_and_indirect_data_word u_port0_flow_ctrl_and_indirect_data_word (.*);

  // ---------------------------------------------------------------
  // Clock, fabric responder and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    I_CORE_CLK = 1'b0;
    forever #25 I_CORE_CLK = ~I_CORE_CLK;
  end

  // Slow fabric: acknowledge after eight request cycles, log request
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      req_cnt <= 0;
      I_FAB_ACK <= 1'b0;
    end
    else
    begin
      req_cnt <= (O_FAB_REQ === 1'b1) ? req_cnt + 1 : 0;
      I_FAB_ACK <= (req_cnt == 8);
    end
    I_FAB_RDATA <= {16'hC0DE, O_FAB_INDEX};
    if (req_cnt == 8)
    begin
      seen_index <= O_FAB_INDEX;
      seen_wdata <= O_FAB_WDATA;
      seen_read <= O_FAB_READ;
    end
  end

  initial
  begin
    #1000000;
    fails++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= s;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge I_CORE_CLK);
      if (!aw_done && O_AWREADY === 1'b1)
      begin
        aw_done = 1;
        I_AWVALID <= 1'b0;
      end
      if (!w_done && O_WREADY === 1'b1)
      begin
        w_done = 1;
        I_WVALID <= 1'b0;
      end
    end
    do @(posedge I_CORE_CLK); while (O_BVALID !== 1'b1);
    rs = O_BRESP;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    do @(posedge I_CORE_CLK); while (O_ARREADY !== 1'b1);
    I_ARVALID <= 1'b0;
    do @(posedge I_CORE_CLK); while (O_RVALID !== 1'b1);
    rd = O_RDATA;
    rs = O_RRESP;
  endtask : axi_read

  task automatic do_reset();
    I_RST_N <= 1'b0;
    repeat (3) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    repeat (3) @(posedge I_CORE_CLK);
  endtask : do_reset

  // Polls the command register until the access has finished
  // no writes while busy
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      axi_read(`FC_IND_CMD_ADDR);
      n++;
    end
    while (rd[31] !== 1'b0 && n < 50);
  endtask : wait_idle

  // Sets link inputs, lets status settle, then reads the flow register
  task automatic flow_case(input logic aneg, input logic half,
                           input logic nrx, input logic ntx,
                           input logic [31:0] wr, input logic [31:0] exp);
    logic [2:0] pins;
    I_ANEG_ENABLE <= aneg;
    I_LINK_HALF_DUPLEX <= half;
    I_NEG_RX_PAUSE <= nrx;
    I_NEG_TX_PAUSE <= ntx;
    axi_write(`FC_FLOW_CFG_ADDR, wr, 4'hF);
    repeat (3) @(posedge I_CORE_CLK);
    axi_read(`FC_FLOW_CFG_ADDR);
    `CHECK(rd, exp)
    pins = {O_BACKPRESSURE_EN, O_RX_PAUSE_EN, O_TX_PAUSE_EN};
    `CHECK(pins, {exp[6], exp[4:3]})
  endtask : flow_case

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset_values();
    axi_read(`FC_FLOW_CFG_ADDR);
    `CHECK(rd, 32'h0000_005E)
    `CHECK(rd[5:3], 3'h3)
    axi_read(`FC_IND_DATA_ADDR);
    `CHECK(rd, 32'h0000_0000)
    axi_read(12'h100);
    `CHECK(rs, 2'h2)
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_flow_modes();
    // Reserved and status bits ignore writes
    flow_case(1'b0, 1'b0, 1'b0, 1'b0, 32'hFFFF_FFE1, 32'h0000_0041);
    flow_case(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0007, 32'h0000_001F);
    flow_case(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0006, 32'h0000_0016);
    flow_case(1'b0, 1'b0, 1'b1, 1'b0, 32'h0000_0006, 32'h0000_001E);
    flow_case(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0006, 32'h0000_0026);
    axi_write(`FC_FLOW_CFG_ADDR, 32'h0000_0040, 4'h0);
    axi_read(`FC_FLOW_CFG_ADDR);
    `CHECK(rd, 32'h0000_0026)
    $display("test flow modes done");
  endtask : test_flow_modes

  task automatic test_ext_mac();
    I_EXT_MAC_MODE <= 1'b1;
    I_LINK_HALF_DUPLEX <= 1'b0;
    do_reset();
    axi_read(`FC_FLOW_CFG_ADDR);
    `CHECK(rd[0], 1'b1)
    flow_case(1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0006, 32'h0000_001F);
    I_EXT_MAC_MODE <= 1'b0;
    do_reset();
    $display("test external mode done");
  endtask : test_ext_mac

  task automatic test_fabric_write();
    axi_write(`FC_IND_CMD_ADDR, 32'h0000_0012, 4'hF);
    axi_write(`FC_IND_DATA_ADDR, 32'hA5A5_1234, 4'hF);
    axi_write(`FC_IND_CMD_ADDR, 32'h8000_0012, 4'hF);
    axi_read(`FC_IND_CMD_ADDR);
    `CHECK(rd[31], 1'b1)
    wait_idle();
    `CHECK(rd[31], 1'b0)
    `CHECK(seen_read, 1'b0)
    `CHECK(seen_index, 16'h0012)
    `CHECK(seen_wdata, 32'hA5A5_1234)
    axi_read(`FC_IND_DATA_ADDR);
    `CHECK(rd, 32'hA5A5_1234)
    $display("test fabric write done");
  endtask : test_fabric_write

  task automatic test_fabric_read();
    axi_write(`FC_IND_CMD_ADDR, 32'hC000_0034, 4'hF);
    wait_idle();
    `CHECK(seen_read, 1'b1)
    axi_read(`FC_IND_DATA_ADDR);
    `CHECK(rd, 32'hC0DE_0034)
    $display("test fabric read done");
  endtask : test_fabric_read

  task automatic test_auto_inc();
    axi_write(`FC_IND_CMD_ADDR, 32'h2000_0050, 4'hF);
    axi_write(`FC_IND_DATA_ADDR, 32'h1111_2222, 4'hF);
    wait_idle();
    `CHECK({seen_index, seen_wdata}, {16'h0050, 32'h1111_2222})
    `CHECK(rd, 32'h2000_0051)
    axi_write(12'h100, 32'h0000_0001, 4'hF);
    `CHECK(rs, 2'h2)
    $display("test auto increment done");
  endtask : test_auto_inc

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {I_AWVALID, I_WVALID, I_ARVALID, I_EXT_MAC_MODE} = 4'h0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB} = '0;
    {I_BREADY, I_RREADY, I_RST_N} = 3'h7;
    {I_STRAP_BP_EN, I_STRAP_FD_FC} = 2'h3;
    {I_STRAP_MANUAL_FC, I_STRAP_HALF_DUPLEX} = 2'h0;
    {I_ANEG_ENABLE, I_LINK_HALF_DUPLEX} = 2'h0;
    {I_NEG_RX_PAUSE, I_NEG_TX_PAUSE} = 2'h0;
    fails = 0;
    total_checks = 0;
    do_reset();
    test_reset_values();
    test_flow_modes();
    test_ext_mac();
    test_fabric_write();
    test_fabric_read();
    test_auto_inc();
    summarize();
  end
endmodule : testbench
